// ===== include/eqf_regs.vh
// Register map, field layout and reset values of the equalizer filter coefficient block
`ifndef EQF_REGS_VH
`define EQF_REGS_VH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define EQF_OFF_SELECT    12'h410
`define EQF_OFF_CTRL      12'h411
`define EQF_OFF_STATUS    12'h412
`define EQF_OFF_TAP0      12'h418
`define EQF_OFF_TAP1      12'h41a
`define EQF_OFF_TAP2      12'h41c
`define EQF_OFF_TAP3      12'h41e
`define EQF_OFF_TAP4      12'h420
`define EQF_OFF_TAP5      12'h423
`define EQF_OFF_TAP6      12'h425
`define EQF_OFF_TAP7      12'h427
`define EQF_OFF_TAP8      12'h429

// ------------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------------
`define EQF_NARROW_MSB    11
`define EQF_CENTER_MSB    17
`define EQF_COEF_W        18
`define EQF_NUM_TAPS      9
`define EQF_CENTER_IDX    4'h4
`define EQF_NO_TAP        4'hf
`define EQF_NARROW_MASK   24'h00ffff
`define EQF_CENTER_MASK   24'hffffff
`define EQF_SEL_MSB       1
`define EQF_CTRL_LINK_BIT 0

// ------------------------------------------------------------------
// Reset values and mode codes
// ------------------------------------------------------------------
`define EQF_COEF_RST      24'h000000
`define EQF_SEL_RST       2'h0
`define EQF_SEL_BYPASS    2'h0
`define EQF_SEL_ENABLE    2'h2
`define EQF_LINK_RST      1'h0

`endif

// ===== design/eqf_fir.v
// Nine-tap programmable equalizer filter with coefficient registers and output buffer
//
// Notes on behaviour
// - Non-centre coefficients: 12-bit signed, low bits
// - Nine taps; fifth is 18-bit signed centre
// - Centre coefficient drives the fifth tap
// - Sixth-tap coefficient drives the sixth tap
// - Centre register at 0x420, resets to zero
// - Sixth-tap register at 0x423, resets to zero
// - Select 0 bypasses, 2 enables; others reserved
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`include "eqf_regs.vh"

module eqf_fir #(
   parameter DATA_W = 12,
   parameter OUT_W  = 34,
   parameter ADDR_W = 12,
   parameter REG_W  = 24
) (
   input  wire                     core_clk,
   input  wire                     rst,
   input  wire [ADDR_W-1:0]        reg_addr,
   input  wire [REG_W-1:0]         reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [REG_W-1:0]         reg_rdata,
   input  wire [DATA_W-1:0]        in_data,
   input  wire                     in_valid,
   output reg                      in_ready,
   output reg  [OUT_W-1:0]         out_data,
   output reg                      out_valid,
   input  wire                     out_ready,
   output reg                      serial_link_enable,
   output reg                      filter_active
);

   // ------------------------------------------------------------------
   // Local sizes
   // ------------------------------------------------------------------
   localparam PROD_W = DATA_W + `EQF_COEF_W;
   localparam NTAP   = `EQF_NUM_TAPS;

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   reg [REG_W-1:0]  coef_r [0:NTAP-1];      // Coefficient registers, tap order
   reg [DATA_W-1:0] hist_r [0:NTAP-2];      // Past samples, newest first
   reg [1:0]        filter_select_r;
   reg [OUT_W-1:0]  slot1_r;                // Second buffer entry
   reg              valid1_r;

   reg [OUT_W-1:0]  slot0_nxt;
   reg [OUT_W-1:0]  slot1_nxt;
   reg              valid0_nxt;
   reg              valid1_nxt;
   reg [OUT_W-1:0]  result;
   reg signed [OUT_W-1:0] acc;
   reg signed [PROD_W-1:0] prod;
   reg [DATA_W-1:0] samp;
   reg [3:0]        wr_idx;
   reg [3:0]        rd_idx;
   reg [REG_W-1:0]  rd_val;

   wire push;
   wire pop;
   integer k_rst;
   integer k_sum;
   integer k_hist;

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   // Map a register address to a tap index, or no tap
   function [3:0] tap_index;
      input [ADDR_W-1:0] a;
      begin
         case (a)
            `EQF_OFF_TAP0: tap_index = 4'h0;
            `EQF_OFF_TAP1: tap_index = 4'h1;
            `EQF_OFF_TAP2: tap_index = 4'h2;
            `EQF_OFF_TAP3: tap_index = 4'h3;
            `EQF_OFF_TAP4: tap_index = `EQF_CENTER_IDX;
            `EQF_OFF_TAP5: tap_index = 4'h5;
            `EQF_OFF_TAP6: tap_index = 4'h6;
            `EQF_OFF_TAP7: tap_index = 4'h7;
            `EQF_OFF_TAP8: tap_index = 4'h8;
            default:       tap_index = `EQF_NO_TAP;
         endcase
      end
   endfunction

   // Implemented width of each coefficient register
   function [REG_W-1:0] tap_mask;
      input [3:0] idx;
      begin
         if (idx == `EQF_CENTER_IDX) begin
            tap_mask = `EQF_CENTER_MASK;
         end else begin
            tap_mask = `EQF_NARROW_MASK;
         end
      end
   endfunction

   // Signed coefficient value used by the multiplier
   function [`EQF_COEF_W-1:0] tap_coef;
      input [3:0]       idx;
      input [REG_W-1:0] raw;
      begin
         if (idx == `EQF_CENTER_IDX) begin
            tap_coef = raw[`EQF_CENTER_MSB:0];
         end else begin
            tap_coef = {{(`EQF_COEF_W-`EQF_NARROW_MSB-1){raw[`EQF_NARROW_MSB]}},
                        raw[`EQF_NARROW_MSB:0]};
         end
      end
   endfunction

   // ------------------------------------------------------------------
   // Register write path
   // ------------------------------------------------------------------
   // Address decode for writes
   always @* begin
      wr_idx = tap_index(reg_addr);
   end

   // Coefficient registers clear to zero and store zero in bits outside the tap mask
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (k_rst = 0; k_rst < NTAP; k_rst = k_rst + 1) begin
            coef_r[k_rst] <= `EQF_COEF_RST;
         end
      end else if (reg_wr && wr_idx != `EQF_NO_TAP) begin
         coef_r[wr_idx] <= reg_wdata & tap_mask(wr_idx);
      end
   end

   // Filter select and link enable control
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         filter_select_r    <= `EQF_SEL_RST;
         serial_link_enable <= `EQF_LINK_RST;
      end else if (reg_wr) begin
         if (reg_addr == `EQF_OFF_SELECT) begin
            filter_select_r <= reg_wdata[`EQF_SEL_MSB:0];
         end
         if (reg_addr == `EQF_OFF_CTRL) begin
            serial_link_enable <= reg_wdata[`EQF_CTRL_LINK_BIT];
         end
      end
   end

   // ------------------------------------------------------------------
   // Register read path
   // ------------------------------------------------------------------
   // Read mux; unmapped addresses read zero
   always @* begin
      rd_idx = tap_index(reg_addr);
      rd_val = {REG_W{1'b0}};
      if (rd_idx != `EQF_NO_TAP) begin
         rd_val = coef_r[rd_idx];
      end else begin
         case (reg_addr)
            `EQF_OFF_SELECT: rd_val[`EQF_SEL_MSB:0] = filter_select_r;
            `EQF_OFF_CTRL:   rd_val[`EQF_CTRL_LINK_BIT] = serial_link_enable;
            `EQF_OFF_STATUS: rd_val[2:0] = {valid1_r, out_valid, filter_active};
            default:         rd_val = {REG_W{1'b0}};
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= {REG_W{1'b0}};
      end else if (reg_rd) begin
         reg_rdata <= rd_val;
      end else begin
         reg_rdata <= {REG_W{1'b0}};
      end
   end

   // ------------------------------------------------------------------
   // Filter datapath
   // ------------------------------------------------------------------
   assign push = in_valid & in_ready;
   assign pop  = out_valid & out_ready;

   // Mode decode; reserved codes behave as bypass
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         filter_active <= 1'b0;
      end else begin
         filter_active <= (filter_select_r == `EQF_SEL_ENABLE);
      end
   end

   // Sum of products over the newest nine samples, tap order
   always @* begin
      acc  = {OUT_W{1'b0}};
      prod = {PROD_W{1'b0}};
      samp = in_data;
      for (k_sum = 0; k_sum < NTAP; k_sum = k_sum + 1) begin
         if (k_sum == 0) begin
            samp = in_data;
         end else begin
            samp = hist_r[k_sum-1];
         end
         prod = $signed(samp) * $signed(tap_coef(k_sum[3:0], coef_r[k_sum]));
         acc  = acc + $signed({{(OUT_W-PROD_W){prod[PROD_W-1]}}, prod});
      end
      if (filter_active) begin
         result = acc;
      end else begin
         result = {{(OUT_W-DATA_W){in_data[DATA_W-1]}}, in_data};
      end
   end

   // Sample history advances on each accepted input
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (k_hist = 0; k_hist < NTAP-1; k_hist = k_hist + 1) begin
            hist_r[k_hist] <= {DATA_W{1'b0}};
         end
      end else if (push) begin
         hist_r[0] <= in_data;
         for (k_hist = 1; k_hist < NTAP-1; k_hist = k_hist + 1) begin
            hist_r[k_hist] <= hist_r[k_hist-1];
         end
      end
   end

   // ------------------------------------------------------------------
   // Two-entry output buffer
   // ------------------------------------------------------------------
   // Next state: pop first, then place a new word in the first free slot
   always @* begin
      slot0_nxt  = out_data;
      slot1_nxt  = slot1_r;
      valid0_nxt = out_valid;
      valid1_nxt = valid1_r;
      if (pop) begin
         slot0_nxt  = slot1_r;
         valid0_nxt = valid1_r;
         valid1_nxt = 1'b0;
      end
      if (push) begin
         if (!valid0_nxt) begin
            slot0_nxt  = result;
            valid0_nxt = 1'b1;
         end else begin
            slot1_nxt  = result;
            valid1_nxt = 1'b1;
         end
      end
   end

   // Buffer registers; ready is low in reset and until the first edge after it, otherwise only while both slots are held
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_data  <= {OUT_W{1'b0}};
         out_valid <= 1'b0;
         slot1_r   <= {OUT_W{1'b0}};
         valid1_r  <= 1'b0;
         in_ready  <= 1'b0;
      end else begin
         out_data  <= slot0_nxt;
         out_valid <= valid0_nxt;
         slot1_r   <= slot1_nxt;
         valid1_r  <= valid1_nxt;
         in_ready  <= ~valid1_nxt;
      end
   end

endmodule

// ===== tb/eqf_fir_chk.sv
// Port-level checks of the equalizer filter block
`timescale 1ns/10ps
module eqf_fir_chk (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [11:0] reg_addr,
   input wire logic [23:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [23:0] reg_rdata,
   input wire logic [11:0] in_data,
   input wire logic        in_valid,
   input wire logic        in_ready,
   input wire logic [33:0] out_data,
   input wire logic        out_valid,
   input wire logic        out_ready,
   input wire logic        serial_link_enable,
   input wire logic        filter_active
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Register port, mode and stream relations
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 24'h000000)
      else $error("read data not zero outside read cycle");
   a_link_mirror: assert property (reg_wr && reg_addr == 12'h411 |=> serial_link_enable == $past(reg_wdata[0]))
      else $error("link enable does not follow control write");
   a_select_active: assert property (reg_wr && reg_addr == 12'h410 |=> ##1
      filter_active == ($past(reg_wdata[1:0], 2) == 2'h2))
      else $error("filter active does not match select code");
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output changed while stalled");
   a_accept_out: assert property (in_valid && in_ready |=> out_valid)
      else $error("accepted sample gave no output");
   a_full_refuse: assert property (!in_ready && !$past(rst) |-> out_valid)
      else $error("input refused with empty buffer");
   a_ready_rise: assert property (out_valid && out_ready && !in_ready |=> in_ready)
      else $error("input ready did not return after pop");
   a_bypass_pass: assert property (!filter_active && in_valid && in_ready && !out_valid |=>
      out_data == {{22{$past(in_data[11])}}, $past(in_data)})
      else $error("bypass output is not the input sample");
endmodule
bind eqf_fir eqf_fir_chk eqf_fir_chk_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_data(in_data),
   .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
   .out_ready(out_ready), .serial_link_enable(serial_link_enable), .filter_active(filter_active));

// ===== tb/tb_eqf_fir.sv
// Self-checking bench of the equalizer filter block
`timescale 1ns/10ps
module tb_eqf_fir;
   logic              core_clk, rst, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready;
   logic              serial_link_enable, filter_active;
   logic [11:0]       reg_addr, in_data;
   logic [23:0]       reg_wdata, reg_rdata;
   logic [33:0]       out_data;
   logic [33:0]       exp_q[$];
   logic signed [11:0] hist[9] = '{default: 0};
   logic signed [17:0] coef[9] = '{default: 0};
   logic [11:0]       smp[8] = '{12'h001, 12'h7ff, 12'h800, 12'h123, 12'hfff, 12'h010, 12'h400, 12'hc00};
   logic [1:0]        sel;
   int                errors, cmp_count, m;

   eqf_fir eqf_fir_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_data(in_data), .in_valid(in_valid),
      .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
      .serial_link_enable(serial_link_enable), .filter_active(filter_active));

   // Clock of 10 ns
   always #5 core_clk = ~core_clk;

   task final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task check(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [11:0] a, input logic [23:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1;
      @(posedge core_clk);
      reg_wr <= 0;
      if (a == 12'h410) sel = d[1:0];
   endtask

   task rd_chk(input logic [11:0] a, input logic [23:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1;
      @(posedge core_clk);
      reg_rd <= 0;
      #1 check(34'(reg_rdata), 34'(e));
   endtask

   // Sends the sample table and records each expected result at its accept edge
   task send();
      int t;
      logic signed [33:0] acc;
      @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         in_data  <= smp[i];
         in_valid <= 1;
         t = 0;
         do begin @(negedge core_clk); t++; end while (in_ready !== 1'b1 && t < 100);
         if (in_ready !== 1'b1) begin errors++; final_report(); end
         @(posedge core_clk);
         for (int k = 8; k > 0; k--) hist[k] = hist[k-1];
         hist[0] = smp[i];
         acc = (sel == 2'h2) ? 0 : hist[0];
         if (sel == 2'h2) for (int k = 0; k < 9; k++) acc += coef[k] * hist[k];
         exp_q.push_back(acc);
      end
      in_valid <= 0;
   endtask

   // Burst with the sink stalled until both buffer slots are full
   task burst();
      fork
         send();
         begin
            @(posedge core_clk);
            out_ready <= 0;
            repeat (6) @(negedge core_clk);
            check(34'(in_ready), 34'h0);
            rd_chk(12'h412, {21'h0, 2'b11, sel == 2'h2});
            @(posedge core_clk);
            out_ready <= 1;
         end
      join
      repeat (4) @(negedge core_clk);
      check(34'(out_valid), 34'h0);
   endtask

   // Compares every popped result with the queue of expectations
   always @(negedge core_clk) begin
      if (rst === 1'b0 && out_valid === 1'b1 && out_ready === 1'b1) check(out_data, exp_q.pop_front());
   end

   // Main sequence
   initial begin
      {core_clk, reg_wr, reg_rd, in_valid, sel, errors, cmp_count} = 0;
      {reg_addr, reg_wdata, in_data} = 0;
      rst = 1;
      out_ready = 1;
      repeat (10) @(posedge core_clk);
      rst <= 0;
      rd_chk(12'h420, 24'h000000);
      rd_chk(12'h423, 24'h000000);
      rd_chk(12'h410, 24'h000000);
      wr(12'h420, 24'hffffff);
      rd_chk(12'h420, 24'hffffff);
      wr(12'h423, 24'hffffff);
      rd_chk(12'h423, 24'h00ffff);
      wr(12'h421, 24'h00abcd);
      rd_chk(12'h421, 24'h000000);
      for (m = 0; m < 4; m++) begin
         wr(12'h410, 24'(m));
         rd_chk(12'h410, 24'(m));
         check(34'(filter_active), 34'(m == 2));
      end
      burst();
      wr(12'h420, 24'hfe0000);
      coef[4] = 18'h20000;
      rd_chk(12'h420, 24'hfe0000);
      wr(12'h423, 24'h00f801);
      coef[5] = 18'h3f801;
      rd_chk(12'h423, 24'h00f801);
      wr(12'h418, 24'h000003);
      coef[0] = 18'h00003;
      wr(12'h410, 24'h000002);
      rd_chk(12'h412, 24'h000001);
      burst();
      wr(12'h410, 24'h000000);
      burst();
      wr(12'h411, 24'h000001);
      #1 check(34'(serial_link_enable), 34'h1);
      wr(12'h411, 24'h000000);
      check(34'(exp_q.size()), 34'h0);
      final_report();
   end
endmodule
